//--- core/scr_pkg.sv
// package of constants for the serial channel clock and receive path
package scr_pkg;
    // register indices on the plain register port
    localparam logic [3:0] SCR_REG_MODE = 4'h0;
    localparam logic [3:0] SCR_REG_CTRL = 4'h1;
    localparam logic [3:0] SCR_REG_RATE = 4'h2;
    localparam logic [3:0] SCR_REG_BUF = 4'h3;
    // mode register fields
    localparam int SCR_MODE_LO = 0;
    localparam int SCR_SRC_LO = 2;
    localparam int SCR_WU_BIT = 4;
    localparam int SCR_RXE_BIT = 5;
    // control register fields
    localparam int SCR_PE_BIT = 0;
    localparam int SCR_IOC_BIT = 1;
    localparam int SCR_EDGE_BIT = 2;
    localparam int SCR_FRAMING_FLAG_BIT = 4;
    localparam int SCR_OVERRUN_FLAG_BIT = 5;
    localparam int SCR_RB8_BIT = 7;
    // rate register fields
    localparam int SCR_DIV_LO = 0;
    localparam int SCR_TAP_LO = 4;
    // reset values
    localparam logic [7:0] SCR_MODE_RST = 8'h00;
    localparam logic [7:0] SCR_CTRL_RST = 8'h00;
    localparam logic [7:0] SCR_RATE_RST = 8'h00;
    // prescaler tap positions: fc/4, fc/16, fc/64, fc/256
    localparam int SCR_PRE_W = 8;
    localparam int SCR_TAP4 = 1;
    localparam int SCR_TAP16 = 3;
    localparam int SCR_TAP64 = 5;
    localparam int SCR_TAP256 = 7;
    localparam logic [3:0] SCR_SAMPLE_A = 4'h7;
    localparam logic [3:0] SCR_SAMPLE_C = 4'h9;
    localparam logic [3:0] SCR_BIT_LAST = 4'hF;
    localparam logic [3:0] SCR_SYNC_BITS = 4'h8;

    typedef enum logic [1:0] {
        SCR_M_SYNC = 2'b00,
        SCR_M_UART7 = 2'b01,
        SCR_M_UART8 = 2'b10,
        SCR_M_UART9 = 2'b11
    } scr_mode_e;

    typedef enum logic [1:0] {
        SCR_S_TIMER = 2'b00,
        SCR_S_RATE = 2'b01,
        SCR_S_INT = 2'b10,
        SCR_S_EXT = 2'b11
    } scr_src_e;
endpackage : scr_pkg

//--- core/scr_rate_gen.sv
// prescaler tap select and 4-bit rate divider
`timescale 1ns/1ps
module scr_rate_gen
    import scr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // configuration
    input wire logic [1:0] prescale_tap_select_i,
    input wire logic [3:0] divisor_i,
    // tick outputs
    output logic tap_tick_o,
    output logic rate_tick_o,
    output logic int_tick_o
);
    logic [SCR_PRE_W-1:0] pre_q;
    logic [SCR_PRE_W-1:0] pre_d;
    logic [3:0] div_q;
    logic [3:0] div_last;
    logic tap_sel;

    assign pre_d = SCR_PRE_W'(pre_q + 1'b1);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_d;
        end
    end

    // tick when the chosen prescaler bit rolls over
    always_comb begin
        unique case (prescale_tap_select_i)
            2'd0: tap_sel = &pre_q[SCR_TAP4:0];
            2'd1: tap_sel = &pre_q[SCR_TAP16:0];
            2'd2: tap_sel = &pre_q[SCR_TAP64:0];
            2'd3: tap_sel = &pre_q[SCR_TAP256:0];
        endcase
    end
    assign tap_tick_o = tap_sel;
    assign int_tick_o = pre_q[0];

    // divisor 0 stands for 16; 1 is treated as 2, the least legal divisor
    assign div_last = (divisor_i == 4'h1) ? 4'h1 : 4'(divisor_i - 4'h1);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= '0;
        end else if (tap_sel) begin
            div_q <= (div_q == div_last) ? 4'h0 : 4'(div_q + 4'h1);
        end
    end
    assign rate_tick_o = tap_sel && (div_q == div_last);

    rate_period_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (prescale_tap_select_i == 2'd0 && divisor_i == 4'h2 && rate_tick_o)
        ##1 (prescale_tap_select_i == 2'd0 && divisor_i == 4'h2) [*7]
        |-> !rate_tick_o)
        else $error("rate tick came early");
endmodule : scr_rate_gen

//--- core/scr_serial_rx.sv
// serial channel clock generation and receive path
//
// Overview of operation
// - rate input from one of four prescaler taps
// - four-bit divider divides tap by 2 to 16
// - sync internal clock: rate output halved
// - sync bit rate eight times uart rate
// - external source in uart modes: base tick from divider
// - uart tick from divider, fc/2 or timer
// - timer match never clocks sync mode
// - sixteen ticks per bit, majority of 7-9
// - start needs two low samples of three
// - sync internal clock: sample on rising edge
// - sync external clock: sample on chosen edge
// - full frame moves to buffer, raises interrupt
// - uart shift stage keeps receiving while buffer unread; sync mode stops
// - overrun keeps buffer, drops shift stage
// - parity or ninth bit captured separately
// - wake-up: interrupt only when ninth bit set
// - transmit tick every sixteen base ticks in uart modes; none in sync mode
// - reading control register clears error flags
// - stop bit majority low sets framing flag, except in nine-bit frames
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module scr_serial_rx
    import scr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // timer and line
    input wire logic timer_match_i,
    input wire logic rxd_i,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    // events
    output logic receive_interrupt_o,
    output logic transmit_bit_tick_o
);
    logic [7:0] mode_q;
    logic [7:0] ctrl_q;
    logic [7:0] rate_q;
    logic [7:0] rdata_q;
    scr_mode_e mode;
    scr_src_e uart_tick_source;
    logic wake_up_enable, rx_enable, parity_en, clock_direction_select, shift_edge_select;
    logic tap_tick, rate_tick, int_tick;
    logic serial_base_tick;
    logic half_q, sclk_q, sclk_prev_q;
    logic sync_mode, shift_tick, ext_edge;
    logic [3:0] rx_cnt_q, tx_cnt_q;
    logic [2:0] smp_q;
    logic maj;
    logic rxd_prev_q, start_edge;
    logic busy_q;
    logic [3:0] bit_idx_q;
    logic [3:0] frame_bits;
    logic [8:0] shift_q;
    logic [7:0] hold_q;
    logic full_q;
    logic received_ninth_bit_q, overrun_flag_q, framing_flag_q;
    logic buf_rd, ctrl_rd, frame_done, stop_phase;
    logic [8:0] frame_word;

    assign mode = scr_mode_e'(mode_q[SCR_MODE_LO +: 2]);
    assign uart_tick_source = scr_src_e'(mode_q[SCR_SRC_LO +: 2]);
    assign wake_up_enable = mode_q[SCR_WU_BIT];
    assign rx_enable = mode_q[SCR_RXE_BIT];
    assign parity_en = ctrl_q[SCR_PE_BIT];
    assign clock_direction_select = ctrl_q[SCR_IOC_BIT];
    assign shift_edge_select = ctrl_q[SCR_EDGE_BIT];
    assign sync_mode = (mode == SCR_M_SYNC);
    assign buf_rd = rd_i && addr_i == SCR_REG_BUF;
    assign ctrl_rd = rd_i && addr_i == SCR_REG_CTRL;

    scr_rate_gen u_rate (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .prescale_tap_select_i(rate_q[SCR_TAP_LO +: 2]),
        .divisor_i(rate_q[SCR_DIV_LO +: 4]),
        .tap_tick_o(tap_tick),
        .rate_tick_o(rate_tick),
        .int_tick_o(int_tick)
    );

    // register writes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= SCR_MODE_RST;
            ctrl_q <= SCR_CTRL_RST;
            rate_q <= SCR_RATE_RST;
        end else if (wr_i) begin
            unique case (addr_i)
                SCR_REG_MODE: mode_q <= wdata_i;
                SCR_REG_CTRL: ctrl_q <= wdata_i;
                SCR_REG_RATE: rate_q <= wdata_i;
                default: ;
            endcase
        end
    end

    // base tick selection; the timer is only offered in uart modes
    always_comb begin
        unique case (uart_tick_source)
            SCR_S_TIMER: serial_base_tick = timer_match_i;
            SCR_S_RATE: serial_base_tick = rate_tick;
            SCR_S_INT: serial_base_tick = int_tick;
            SCR_S_EXT: serial_base_tick = rate_tick;
        endcase
        if (sync_mode) begin
            serial_base_tick = rate_tick;
        end
    end

    timer_block_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (sync_mode && timer_match_i && !rate_tick) |-> !serial_base_tick)
        else $error("timer match clocked shift mode");

    // internal shift clock: rate output halved; runs only while a frame is taken
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            half_q <= 1'b0;
            sclk_q <= 1'b1;
        end else if (sync_mode && !clock_direction_select && rx_enable && !full_q) begin
            if (rate_tick) begin
                half_q <= ~half_q;
                sclk_q <= half_q;
            end
        end else begin
            half_q <= 1'b0;
            sclk_q <= 1'b1;
        end
    end
    assign sclk_o = sclk_q;
    assign sclk_oe_o = sync_mode && !clock_direction_select;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_prev_q <= 1'b1;
        end else begin
            sclk_prev_q <= sclk_i;
        end
    end
    // edge select 0 takes rising edges, 1 falling
    assign ext_edge = shift_edge_select ? (sclk_prev_q && !sclk_i)
                                        : (!sclk_prev_q && sclk_i);
    // one bit per two rate ticks, against sixteen in uart modes
    assign shift_tick = sync_mode && rx_enable && !full_q &&
        (clock_direction_select ? ext_edge
                                : (rate_tick && half_q));

    // transmit bit tick counter
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_cnt_q <= '0;
        end else if (!sync_mode && serial_base_tick) begin
            tx_cnt_q <= 4'(tx_cnt_q + 4'h1);
        end
    end
    assign transmit_bit_tick_o = !sync_mode && serial_base_tick && tx_cnt_q == SCR_BIT_LAST;

    // a fall of the idle line restarts the bit count, so the votes sit mid-bit;
    // idle level after reset is high, so no false start follows reset
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_prev_q <= rxd_i;
        end
    end
    assign start_edge = !busy_q && rxd_prev_q && !rxd_i;

    // receive counter and majority sampling
    assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & rxd_i) | (smp_q[1] & rxd_i);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_cnt_q <= '0;
            smp_q <= '1;
        end else if (sync_mode || !rx_enable) begin
            rx_cnt_q <= '0;
        end else if (start_edge) begin
            rx_cnt_q <= '0;
        end else if (serial_base_tick) begin
            rx_cnt_q <= 4'(rx_cnt_q + 4'h1);
            if (rx_cnt_q >= SCR_SAMPLE_A && rx_cnt_q < SCR_SAMPLE_C) begin
                smp_q <= {smp_q[1:0], rxd_i};
            end
        end
    end

    // data bits per frame, parity or ninth bit included, stop bit excluded
    always_comb begin
        unique case (mode)
            SCR_M_SYNC: frame_bits = SCR_SYNC_BITS;
            SCR_M_UART7: frame_bits = parity_en ? 4'd8 : 4'd7;
            SCR_M_UART8: frame_bits = parity_en ? 4'd9 : 4'd8;
            SCR_M_UART9: frame_bits = 4'd9;
        endcase
    end
    // uart frames end at the stop bit unless a ninth bit is carried
    assign stop_phase = !sync_mode && frame_bits != 4'd9;

    logic mid_tick;
    assign mid_tick = !sync_mode && serial_base_tick && rx_cnt_q == SCR_SAMPLE_C;
    assign frame_done = sync_mode ? (shift_tick && bit_idx_q == frame_bits - 4'd1)
        : (mid_tick && busy_q &&
           bit_idx_q == (stop_phase ? frame_bits : 4'(frame_bits - 4'd1)));
    assign frame_word = sync_mode ? {1'b0, rxd_i, shift_q[7:1]}
        : (stop_phase ? shift_q : {maj, shift_q[8:1]});

    // receive sequencing
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_q <= 1'b0;
            bit_idx_q <= '0;
            shift_q <= '0;
        end else if (sync_mode) begin
            busy_q <= 1'b0;
            if (!rx_enable) begin
                bit_idx_q <= '0;
            end else if (shift_tick) begin
                shift_q <= {1'b0, rxd_i, shift_q[7:1]};
                bit_idx_q <= frame_done ? 4'h0 : 4'(bit_idx_q + 4'h1);
            end
        end else if (mid_tick) begin
            if (!busy_q) begin
                busy_q <= !maj;
                bit_idx_q <= '0;
            end else if (frame_done) begin
                busy_q <= 1'b0;
            end else begin
                bit_idx_q <= 4'(bit_idx_q + 4'h1);
                if (bit_idx_q < frame_bits) begin
                    shift_q <= {maj, shift_q[8:1]};
                end
            end
        end else if (!rx_enable) begin
            busy_q <= 1'b0;
        end
    end

    start_vote_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!sync_mode && mid_tick && !busy_q && maj) |=> !busy_q)
        else $error("start taken on high majority");

    // holding buffer, ninth bit and overrun; a new frame beats a same-cycle read
    logic accept;
    assign accept = !(mode == SCR_M_UART9 && wake_up_enable && !frame_word[8]);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hold_q <= '0;
            full_q <= 1'b0;
            received_ninth_bit_q <= 1'b0;
        end else if (frame_done && accept && (!full_q || buf_rd)) begin
            full_q <= 1'b1;
            received_ninth_bit_q <= frame_word[8];
            unique case (mode)
                SCR_M_UART7: hold_q <= parity_en ? frame_word[8:1]
                                                 : {1'b0, frame_word[8:2]};
                SCR_M_UART8: hold_q <= parity_en ? frame_word[7:0] : frame_word[8:1];
                default: hold_q <= frame_word[7:0];
            endcase
        end else if (buf_rd) begin
            full_q <= 1'b0;
        end
    end
    assign receive_interrupt_o = full_q;

    wake_filter_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (frame_done && mode == SCR_M_UART9 && wake_up_enable && !frame_word[8] && !full_q)
        |=> !full_q)
        else $error("wake-up frame raised interrupt");

    // error flags: events win over the clearing read
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            overrun_flag_q <= 1'b0;
            framing_flag_q <= 1'b0;
        end else begin
            if (frame_done && accept && full_q && !buf_rd) begin
                overrun_flag_q <= 1'b1;
            end else if (ctrl_rd) begin
                overrun_flag_q <= 1'b0;
            end
            if (mid_tick && busy_q && bit_idx_q == frame_bits && !maj) begin
                framing_flag_q <= 1'b1;
            end else if (ctrl_rd) begin
                framing_flag_q <= 1'b0;
            end
        end
    end

    overrun_keep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (frame_done && accept && full_q && !buf_rd) |=> overrun_flag_q && $stable(hold_q))
        else $error("overrun lost buffer or flag");
    flag_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (ctrl_rd && !frame_done && !mid_tick) |=> !overrun_flag_q && !framing_flag_q)
        else $error("error flags not cleared by read");

    // read data, one cycle after the strobe
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                SCR_REG_MODE: rdata_q <= mode_q;
                SCR_REG_CTRL: rdata_q <= {received_ninth_bit_q, 1'b0, overrun_flag_q,
                                          framing_flag_q, 1'b0, ctrl_q[2:0]};
                SCR_REG_RATE: rdata_q <= rate_q;
                SCR_REG_BUF: rdata_q <= hold_q;
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end
    assign rdata_o = rdata_q;
endmodule : scr_serial_rx

//--- bench/scr_far_end.sv
// far-side model: remote uart sender and external shift register
`timescale 1ns/1ps
module scr_far_end (
    // clock and shared shift clock wire
    input wire logic clk_i,
    input wire logic sclk_w_i,
    // line outputs
    output logic rxd_o,
    output logic ext_sclk_o
);
    logic line_q = 1'b1;
    logic armed_q = 1'b0;
    logic primed_q = 1'b0;
    logic last_q = 1'b1;
    logic [7:0] sh_q = 8'h00;
    assign rxd_o = armed_q ? sh_q[0] : line_q;
    initial ext_sclk_o = 1'b1;
    // shift only on falls after the first rise, so each bit is steady
    // for half a period on both sides of the device's sampling edge
    always @(posedge clk_i) begin
        last_q <= sclk_w_i;
        if (armed_q && sclk_w_i && !last_q) begin
            primed_q <= 1'b1;
        end
        if (armed_q && primed_q && !sclk_w_i && last_q) begin
            sh_q <= {~sh_q[0], sh_q[7:1]};
        end
    end
    task automatic arm(input logic en, input logic [7:0] d);
        sh_q <= d;
        primed_q <= 1'b0;
        armed_q <= en;
    endtask : arm
    // lsb first; a low stop level lets a scenario break the framing
    task automatic send_uart(input logic [8:0] d, input int nb, input int bc, input logic stp);
        for (int i = 0; i < nb + 2; i++) begin
            line_q <= (i == 0) ? 1'b0 : (i > nb) ? stp : d[i - 1];
            repeat (bc) @(posedge clk_i);
        end
        // one idle edge, so a following frame never overwrites this in the same step
        line_q <= 1'b1;
        @(posedge clk_i);
    endtask : send_uart
    task automatic pulse_low(input int n);
        line_q <= 1'b0;
        repeat (n) @(posedge clk_i);
        line_q <= 1'b1;
    endtask : pulse_low
    // data changes on the edge the device does not sample
    task automatic send_ext(input logic [7:0] d, input logic fall);
        for (int i = 0; i < 8; i++) begin
            ext_sclk_o <= fall;
            line_q <= d[i];
            repeat (8) @(posedge clk_i);
            ext_sclk_o <= ~fall;
            repeat (8) @(posedge clk_i);
        end
        ext_sclk_o <= 1'b1;
        line_q <= ~d[7];
    endtask : send_ext
endmodule : scr_far_end

//--- bench/tb_top.sv
// self-checking bench for the serial channel clock and receive path
`timescale 1ns/1ps
module tb_top;
    import scr_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic timer_match_i = 1'b0;
    logic [7:0] rdata_o;
    logic rxd_i;
    logic ext_sclk;
    logic sclk_w;
    logic sclk_o;
    logic sclk_oe_o;
    logic receive_interrupt_o;
    logic transmit_bit_tick_o;
    int miscompares = 0;
    int checked = 0;
    int tcnt = 0;
    int n;
    logic [7:0] rv;
    typedef struct {logic [7:0] mode; logic [7:0] ctrl; logic [7:0] rate;
        logic [8:0] d; int nb; int bc;} scr_row_s;
    // mode, ctrl, rate, frame, data bits (0: tick only), cycles per bit
    scr_row_s rows[11] = '{
        '{8'h2A, 8'h00, 8'h00, 9'h0A5, 8, 32}, '{8'h29, 8'h01, 8'h00, 9'h0B5, 8, 32},
        '{8'h2B, 8'h00, 8'h00, 9'h03C, 9, 32}, '{8'h2A, 8'h01, 8'h00, 9'h15A, 9, 32},
        '{8'h26, 8'h00, 8'h02, 9'h081, 8, 128}, '{8'h22, 8'h00, 8'h00, 9'h07E, 8, 48},
        '{8'h26, 8'h00, 8'h12, 9'h066, 8, 512}, '{8'h26, 8'h00, 8'h22, 9'h000, 0, 2048},
        '{8'h26, 8'h00, 8'h32, 9'h000, 0, 8192}, '{8'h26, 8'h00, 8'h00, 9'h000, 0, 1024},
        '{8'h2E, 8'h00, 8'h0F, 9'h000, 0, 960}};
    assign sclk_w = sclk_oe_o ? sclk_o : ext_sclk;
    always #5 clk_i = ~clk_i;
    // timer match every third cycle, also running where it must be ignored
    always @(posedge clk_i) begin
        tcnt <= (tcnt == 2) ? 0 : tcnt + 1;
        timer_match_i <= (tcnt == 2);
    end
    scr_serial_rx u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .timer_match_i(timer_match_i), .rxd_i(rxd_i), .sclk_i(sclk_w), .sclk_o(sclk_o),
        .sclk_oe_o(sclk_oe_o), .receive_interrupt_o(receive_interrupt_o),
        .transmit_bit_tick_o(transmit_bit_tick_o));
    scr_far_end u_far (.clk_i(clk_i), .sclk_w_i(sclk_w), .rxd_o(rxd_i),
        .ext_sclk_o(ext_sclk));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge clk_i);
    endtask : rd
    task automatic wait_irq();
        for (int i = 0; i < 4000 && receive_interrupt_o !== 1'b1; i++) @(posedge clk_i);
    endtask : wait_irq
    // cycles between second and third rising edge; the first may be short
    task automatic period(input logic sel, output int cnt);
        logic p;
        logic v;
        int e;
        cnt = 0;
        e = 0;
        p = 1'b1;
        for (int i = 0; i < 30000 && e < 3; i++) begin
            @(negedge clk_i);
            v = sel ? sclk_o : transmit_bit_tick_o;
            if (e == 2) cnt++;
            if (v === 1'b1 && p !== 1'b1) e++;
            p = v;
        end
        @(posedge clk_i);
    endtask : period
    task automatic final_report();
        $display("TB: checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (rows[k]) begin
            wr(SCR_REG_MODE, rows[k].mode);
            wr(SCR_REG_CTRL, rows[k].ctrl);
            wr(SCR_REG_RATE, rows[k].rate);
            period(1'b0, n);
            chk(n[15:0], rows[k].bc[15:0]);
            if (rows[k].nb > 0) begin
                u_far.send_uart(rows[k].d, rows[k].nb, rows[k].bc, 1'b1);
                wait_irq();
                chk(receive_interrupt_o, 1'b1);
                rd(SCR_REG_CTRL, rv);
                if (rows[k].nb == 9) chk(rv[SCR_RB8_BIT], rows[k].d[8]);
                chk(rv[5:4], 2'h0);
                rd(SCR_REG_BUF, rv);
                chk(rv, rows[k].d[7:0]);
            end
            $display("TB: row %0d done", k);
        end
        wr(SCR_REG_MODE, 8'h2A);
        u_far.send_uart(9'h011, 8, 32, 1'b1);
        fork
            u_far.send_uart(9'h022, 8, 32, 1'b1);
            begin
                repeat (100) @(posedge clk_i);
                rd(SCR_REG_BUF, rv);
                chk(rv, 8'h11);
            end
        join
        wait_irq();
        rd(SCR_REG_CTRL, rv);
        chk(rv[SCR_OVERRUN_FLAG_BIT], 1'b0);
        rd(SCR_REG_BUF, rv);
        chk(rv, 8'h22);
        u_far.send_uart(9'h033, 8, 32, 1'b1);
        u_far.send_uart(9'h044, 8, 32, 1'b1);
        repeat (32) @(posedge clk_i);
        rd(SCR_REG_CTRL, rv);
        chk(rv[SCR_OVERRUN_FLAG_BIT], 1'b1);
        rd(SCR_REG_CTRL, rv);
        chk(rv[SCR_OVERRUN_FLAG_BIT], 1'b0);
        rd(SCR_REG_BUF, rv);
        chk(rv, 8'h33);
        $display("TB: overrun test done");
        u_far.send_uart(9'h0F0, 8, 32, 1'b0);
        wait_irq();
        repeat (32) @(posedge clk_i);
        rd(SCR_REG_CTRL, rv);
        chk(rv[SCR_FRAMING_FLAG_BIT], 1'b1);
        rd(SCR_REG_CTRL, rv);
        chk(rv[SCR_FRAMING_FLAG_BIT], 1'b0);
        rd(SCR_REG_BUF, rv);
        u_far.pulse_low(2);
        repeat (400) @(posedge clk_i);
        chk(receive_interrupt_o, 1'b0);
        $display("TB: framing and glitch tests done");
        wr(SCR_REG_MODE, 8'h3B);
        u_far.send_uart(9'h0AA, 9, 32, 1'b1);
        repeat (32) @(posedge clk_i);
        chk(receive_interrupt_o, 1'b0);
        u_far.send_uart(9'h155, 9, 32, 1'b1);
        wait_irq();
        rd(SCR_REG_BUF, rv);
        chk(rv, 8'h55);
        $display("TB: wake-up test done");
        wr(SCR_REG_RATE, 8'h02);
        u_far.arm(1'b1, 8'h69);
        wr(SCR_REG_CTRL, 8'h00);
        wr(SCR_REG_MODE, 8'h20);
        period(1'b1, n);
        chk(n[15:0], 16'h0010);
        chk(sclk_oe_o, 1'b1);
        wait_irq();
        wr(SCR_REG_CTRL, 8'h06);
        u_far.arm(1'b0, 8'h00);
        rd(SCR_REG_BUF, rv);
        chk(rv, 8'h69);
        for (int f = 0; f < 2; f++) begin
            wr(SCR_REG_CTRL, {5'h00, f[0], 2'h2});
            u_far.send_ext(8'h3C ^ f[7:0], f[0]);
            wait_irq();
            chk(sclk_oe_o, 1'b0);
            rd(SCR_REG_BUF, rv);
            chk(rv, 8'h3C ^ f[7:0]);
        end
        $display("TB: shift mode tests done");
        wr(SCR_REG_MODE, 8'h2A);
        u_far.send_uart(9'h0FF, 8, 32, 1'b1);
        wait_irq();
        arst_n_i <= 1'b0;
        @(negedge clk_i);
        chk({receive_interrupt_o, transmit_bit_tick_o, sclk_o, rdata_o}, 16'h0100);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        chk(receive_interrupt_o, 1'b0);
        rd(SCR_REG_MODE, rv);
        chk(rv, SCR_MODE_RST);
        rd(SCR_REG_CTRL, rv);
        chk(rv, SCR_CTRL_RST);
        wr(4'h7, 8'hFF);
        rd(4'h7, rv);
        chk(rv, 8'h00);
        rd(SCR_REG_RATE, rv);
        chk(rv, SCR_RATE_RST);
        $display("TB: reset test done");
        final_report();
    end
    initial begin
        #1_000_000;
        miscompares++;
        final_report();
    end
endmodule : tb_top
